// file: hdl/pdmc_defines.vh
// Purpose: constants for the power-down mode controller
// Assumes: 8-bit registers in the low bits of 32-bit Avalon words
// Notes: register index is the word address; byte address is four times it
`ifndef PDMC_DEFINES_VH
`define PDMC_DEFINES_VH

`define PDMC_IDX_SYSCTRL 16'hfff2
`define PDMC_IDX_MODSTBY 16'hff5e
`define PDMC_IDX_STATUS 16'hff60

`define PDMC_SYSCTRL_RESET 8'h0b
`define PDMC_MODSTBY_RESET 8'h40
`define PDMC_MODSTBY_FIXED 8'h40

`define PDMC_BIT_SOFT_STANDBY 7
`define PDMC_SETTLE_MSB 6
`define PDMC_SETTLE_LSB 4
`define PDMC_BIT_RAM_ENABLE 0
`define PDMC_BIT_CLK_STOP 7
`define PDMC_BIT_TIMER 5
`define PDMC_BIT_SERIAL_A 4
`define PDMC_BIT_SERIAL_B 3
`define PDMC_BIT_DMA 2
`define PDMC_BIT_REFRESH 1
`define PDMC_BIT_CONVERTER 0

`define PDMC_SETTLE_BASE 8192
`define PDMC_SETTLE_SHORT 1024
`define PDMC_SETTLE_SHORT_CODE 3'h6
`define PDMC_SETTLE_ILLEGAL_CODE 3'h7

`endif

// file: hdl/pdmc_settle_timer.v
// Purpose: clock settling wait after software standby exit
// Assumes: start is a one-cycle pulse; counts in system clock states
// Notes: illegal code falls back to the longest wait
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
module pdmc_settle_timer #(
  parameter SETTLE_BASE = `PDMC_SETTLE_BASE,
  parameter SETTLE_SHORT = `PDMC_SETTLE_SHORT
)
(
  input wire mclk,
  input wire rst,
  input wire start,
  input wire [2:0] select,
  output reg busy,
  output reg done
);
  reg [18:0] count;

  function [18:0] waitLength;
    input [2:0] code;
    begin
      if (code == `PDMC_SETTLE_SHORT_CODE)
        waitLength = SETTLE_SHORT[18:0];
      else if (code == `PDMC_SETTLE_ILLEGAL_CODE)
        waitLength = SETTLE_BASE[18:0] << 5;
      else
        waitLength = SETTLE_BASE[18:0] << code;
    end
  endfunction

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      count <= 19'h00000;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start)
      begin
        count <= waitLength(select) - 19'h00001;
        busy <= 1'b1;
      end
      else if (busy)
      begin
        if (count == 19'h00000)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
        else
          count <= count - 19'h00001;
      end
    end
  end
endmodule
`default_nettype wire

// file: hdl/pdmc_power_down.v
// Purpose: power-down mode control with per-module standby
// Assumes: all inputs synchronous to mclk; pins sampled as levels
// Notes: registers on Avalon-MM, one wait state per access
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
module pdmc_power_down #(
  parameter SETTLE_BASE = `PDMC_SETTLE_BASE,
  parameter SETTLE_SHORT = `PDMC_SETTLE_SHORT
)
(
  input wire mclk,
  input wire rst,
  input wire [15:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  input wire sleepInstr,
  input wire resetPinN,
  input wire hwStandbyPinN,
  input wire nmi,
  input wire [2:0] externalIrqLines,
  input wire periphIrq,
  input wire irqMasked,
  output reg cpuHalt,
  output reg cpuRegsUndefined,
  output reg clockRun,
  output reg [5:0] moduleHaltReset,
  output reg refreshHalt,
  output reg refreshCounterClear,
  output reg sysClkPinGate,
  output reg sysClkPinHigh,
  output reg sysClkPinEn,
  output reg portsHighZ,
  output reg interruptStart,
  output reg ramEnable
);
  localparam RUN = 3'h0;
  localparam SLEEP = 3'h1;
  localparam SWSTBY = 3'h2;
  localparam SETTLE = 3'h3;
  localparam HWSTBY = 3'h4;

  reg [2:0] state;
  reg [2:0] next_state;
  reg [7:0] systemControlReg;
  reg [7:0] moduleStandbyReg;
  reg ack;
  reg settleStart;
  wire settleBusy;
  wire settleDone;
  wire chipReset;
  wire softStandby;
  wire hwStandby;
  wire wakeExternal;
  wire wakeSleep;
  wire regWrite;
  wire [5:0] modHalt;

  assign chipReset = ~resetPinN;
  assign softStandby = (state == SWSTBY) || (state == SETTLE);
  assign hwStandby = (state == HWSTBY);
  // nmi always wakes; sleep also wakes on an unmasked periphIrq, software standby on any external line
  assign wakeSleep = nmi | (periphIrq & ~irqMasked);
  assign wakeExternal = nmi | (|externalIrqLines);
  // one wait state so read data comes from a flop
  assign waitrequest = (read | write) & ~ack;
  assign regWrite = write & ack;
  assign modHalt = moduleStandbyReg[5:0];

  pdmc_settle_timer #(
    .SETTLE_BASE(SETTLE_BASE),
    .SETTLE_SHORT(SETTLE_SHORT)
  ) settleTimer (
    .mclk(mclk),
    .rst(rst),
    .start(settleStart),
    .select(systemControlReg[`PDMC_SETTLE_MSB:`PDMC_SETTLE_LSB]),
    .busy(settleBusy),
    .done(settleDone)
  );

  // mode sequencing; pins take priority over any instruction
  always @*
  begin
    next_state = state;
    if (!hwStandbyPinN)
      next_state = HWSTBY;
    else if (chipReset)
      next_state = RUN;
    else
    begin
      case (state)
        RUN:
        begin
          if (sleepInstr)
          begin
            if (systemControlReg[`PDMC_BIT_SOFT_STANDBY])
              next_state = SWSTBY;
            else
              next_state = SLEEP;
          end
        end
        SLEEP:
        begin
          if (wakeSleep)
            next_state = RUN;
        end
        SWSTBY:
        begin
          if (wakeExternal)
            next_state = SETTLE;
        end
        SETTLE:
        begin
          if (settleDone)
            next_state = RUN;
        end
        HWSTBY:
          next_state = RUN;
        default:
          next_state = RUN;
      endcase
    end
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state <= RUN;
      settleStart <= 1'b0;
      interruptStart <= 1'b0;
    end
    else
    begin
      state <= next_state;
      settleStart <= (state == SWSTBY) && (next_state == SETTLE);
      // wake from sleep or settle goes straight to interrupt handling
      interruptStart <= ((state == SLEEP) || (state == SETTLE)) && (next_state == RUN) && !chipReset;
    end
  end

  // hardware standby and reset pin reinitialise both registers;
  // software standby leaves them alone
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      systemControlReg <= `PDMC_SYSCTRL_RESET;
      moduleStandbyReg <= `PDMC_MODSTBY_RESET;
    end
    else if (chipReset || hwStandby || !hwStandbyPinN)
    begin
      systemControlReg <= `PDMC_SYSCTRL_RESET;
      moduleStandbyReg <= `PDMC_MODSTBY_RESET;
    end
    else if (regWrite)
    begin
      // soft standby select changes only on a write, reset pin or hardware standby, so it survives wakeup
      if (address == `PDMC_IDX_SYSCTRL)
        systemControlReg <= writedata[7:0];
      if (address == `PDMC_IDX_MODSTBY)
        moduleStandbyReg <= writedata[7:0] | `PDMC_MODSTBY_FIXED;
    end
  end

  // bus handshake and registered read data
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      ack <= 1'b0;
      readdata <= 32'h00000000;
    end
    else
    begin
      ack <= (read | write) & ~ack;
      if (read & ~ack)
      begin
        case (address)
          `PDMC_IDX_SYSCTRL:
            readdata <= {24'h000000, systemControlReg};
          `PDMC_IDX_MODSTBY:
            readdata <= {24'h000000, moduleStandbyReg};
          `PDMC_IDX_STATUS:
            readdata <= {27'h0, settleBusy, hwStandby, softStandby, state == SLEEP, cpuHalt};
          default:
            readdata <= 32'h00000000;
        endcase
      end
    end
  end

  // status outputs from flops so they never glitch toward peripherals
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cpuHalt <= 1'b0;
      cpuRegsUndefined <= 1'b0;
      clockRun <= 1'b1;
      moduleHaltReset <= 6'h00;
      refreshHalt <= 1'b0;
      refreshCounterClear <= 1'b0;
      sysClkPinGate <= 1'b1;
      sysClkPinHigh <= 1'b0;
      sysClkPinEn <= 1'b1;
      portsHighZ <= 1'b0;
      ramEnable <= 1'b1;
    end
    else
    begin
      cpuHalt <= (next_state != RUN);
      cpuRegsUndefined <= (next_state == HWSTBY);
      clockRun <= (next_state == RUN) || (next_state == SLEEP);
      // refresh bit excluded except in hardware standby: otherwise refresh is held, not reset
      moduleHaltReset[5:2] <= modHalt[5:2] | {4{(next_state == SWSTBY) || (next_state == SETTLE) ||
        (next_state == HWSTBY)}};
      moduleHaltReset[1] <= (next_state == HWSTBY);
      moduleHaltReset[0] <= modHalt[0] | (next_state == SWSTBY) || (next_state == SETTLE) ||
        (next_state == HWSTBY);
      refreshHalt <= modHalt[`PDMC_BIT_REFRESH] | (next_state == SWSTBY) || (next_state == SETTLE) ||
        (next_state == HWSTBY);
      refreshCounterClear <= modHalt[`PDMC_BIT_REFRESH] | (next_state == SWSTBY) || (next_state == SETTLE);
      sysClkPinHigh <= (next_state == SWSTBY) || (next_state == SETTLE);
      sysClkPinGate <= (next_state == RUN) || (next_state == SLEEP);
      sysClkPinEn <= (next_state != HWSTBY) && !moduleStandbyReg[`PDMC_BIT_CLK_STOP];
      portsHighZ <= (next_state == HWSTBY);
      ramEnable <= systemControlReg[`PDMC_BIT_RAM_ENABLE];
    end
  end
endmodule
`default_nettype wire

// file: test/pdmc_power_down_sva.sv
// Purpose: port timing checks of the power-down controller
// Assumes: single mclk domain, rst async active high
// Notes: sleep shows as cpuHalt with clockRun still high
`timescale 1ns/1ps
`default_nettype none
module pdmc_power_down_sva (
  input wire logic mclk,
  input wire logic rst,
  input wire logic sleepInstr,
  input wire logic resetPinN,
  input wire logic hwStandbyPinN,
  input wire logic nmi,
  input wire logic [2:0] externalIrqLines,
  input wire logic periphIrq,
  input wire logic irqMasked,
  input wire logic cpuHalt,
  input wire logic cpuRegsUndefined,
  input wire logic clockRun,
  input wire logic [5:0] moduleHaltReset,
  input wire logic refreshCounterClear,
  input wire logic sysClkPinGate,
  input wire logic sysClkPinHigh,
  input wire logic sysClkPinEn,
  input wire logic portsHighZ
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // external lines excluded: they also end software standby and start the settle wait
  wire pins = resetPinN && hwStandbyPinN && externalIrqLines == 3'h0;
  wire wake = nmi || (periphIrq && !irqMasked);
  wire asleep = pins && cpuHalt && clockRun;
  hw_standby_a: assert property (!hwStandbyPinN && resetPinN |-> ##[1:2] portsHighZ && cpuRegsUndefined
    && moduleHaltReset == 6'h3f) else $error("hardware standby outputs wrong");
  pin_float_a: assert property (portsHighZ |-> !sysClkPinEn && !sysClkPinGate) else $error("clock pin driven");
  sleep_entry_a: assert property (sleepInstr && !cpuHalt && pins && !nmi |-> ##[1:2] cpuHalt)
    else $error("halt instruction ignored");
  sleep_hold_a: assert property ((asleep && !wake) [*2] |=> cpuHalt) else $error("sleep left without cause");
  sleep_wake_a: assert property (asleep && wake |-> ##[1:2] !cpuHalt) else $error("sleep not left");
  soft_standby_a: assert property (!clockRun && !portsHighZ |-> sysClkPinHigh && !sysClkPinGate
    && refreshCounterClear && moduleHaltReset == 6'h3d) else $error("software standby outputs wrong");
  refresh_hold_a: assert property (moduleHaltReset[1] |-> portsHighZ) else $error("refresh reset outside standby");
  reset_pin_a: assert property (!resetPinN && hwStandbyPinN |-> ##[1:2] !cpuHalt && clockRun)
    else $error("reset pin did not restore run");
endmodule
bind pdmc_power_down pdmc_power_down_sva chk (.mclk, .rst, .sleepInstr, .resetPinN, .hwStandbyPinN, .nmi,
  .externalIrqLines, .periphIrq, .irqMasked, .cpuHalt, .cpuRegsUndefined, .clockRun, .moduleHaltReset,
  .refreshCounterClear, .sysClkPinGate, .sysClkPinHigh, .sysClkPinEn, .portsHighZ);
`default_nettype wire

// file: test/pdmc_cpu_model.sv
// Purpose: core model issuing the halt instruction
// Assumes: doSleep is a request level from the bench
// Notes: a halted core executes nothing, so no pulse then
`timescale 1ns/1ps
`default_nettype none
module pdmc_cpu_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic cpuHalt,
  input wire logic doSleep,
  output logic sleepInstr
);
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
      sleepInstr <= 1'h0;
    else
      sleepInstr <= doSleep && !cpuHalt && !sleepInstr;
  end
endmodule
`default_nettype wire

// file: test/test_pdmc_power_down.sv
// Purpose: self-checking bench of the power-down controller
// Assumes: 20 MHz mclk, one wait state per access
// Notes: settle counts shortened through parameters
`timescale 1ns/1ps
`default_nettype none
`include "pdmc_defines.vh"
module test_pdmc_power_down;
  localparam int BASE = 8;
  localparam int SHORT = 4;
  logic mclk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0, doSleep = 1'h0;
  logic resetPinN = 1'h1, hwStandbyPinN = 1'h1, nmi = 1'h0, periphIrq = 1'h0, irqMasked = 1'h0;
  logic [15:0] address = 16'h0;
  logic [31:0] writedata = 32'h0;
  logic [2:0] externalIrqLines = 3'h0;
  logic [31:0] readdata;
  logic [5:0] moduleHaltReset;
  logic waitrequest, sleepInstr, cpuHalt, cpuRegsUndefined, clockRun, refreshHalt, refreshCounterClear;
  logic sysClkPinGate, sysClkPinHigh, sysClkPinEn, portsHighZ, interruptStart, ramEnable;
  logic [2:0] codes [4] = '{3'h6, 3'h0, 3'h2, 3'h7};
  int waits [4] = '{SHORT, BASE, BASE * 4, BASE * 32};
  int fails = 0, checkCount = 0, n, starts = 0;
  pdmc_power_down #(.SETTLE_BASE(BASE), .SETTLE_SHORT(SHORT)) dut (.mclk, .rst, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .sleepInstr, .resetPinN, .hwStandbyPinN, .nmi, .externalIrqLines,
    .periphIrq, .irqMasked, .cpuHalt, .cpuRegsUndefined, .clockRun, .moduleHaltReset, .refreshHalt,
    .refreshCounterClear, .sysClkPinGate, .sysClkPinHigh, .sysClkPinEn, .portsHighZ, .interruptStart,
    .ramEnable);
  pdmc_cpu_model cpu (.mclk, .rst, .cpuHalt, .doSleep, .sleepInstr);
  initial
    forever #25 mclk = ~mclk;
  always @(posedge mclk)
    if (interruptStart === 1'h1)
      starts++;
  task automatic endOfTest;
    $display("comparisons %0d mismatches %0d", checkCount, fails);
    if (fails == 0 && checkCount > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checkCount++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic hang;
    fails++;
    endOfTest();
  endtask
  // request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge mclk);
    address <= a;
    writedata <= {24'h0, d};
    read <= !wr;
    write <= wr;
    // waitrequest and read data are taken at the same rising edge
    do
    begin
      @(posedge mclk);
      k++;
    end
    while (waitrequest !== 1'h0 && k < 20);
    q = readdata;
    read <= 1'h0;
    write <= 1'h0;
    if (k >= 20)
      hang();
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'h1, a, d, q);
  endtask
  task automatic rdchk(input logic [15:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'h0, a, 8'h0, q);
    chk(q, e);
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic sleepNow;
    @(posedge mclk);
    doSleep <= 1'h1;
    @(posedge mclk);
    doSleep <= 1'h0;
    tick(3);
  endtask
  task automatic waitRun;
    n = 0;
    while (cpuHalt !== 1'h0 && n < 400)
    begin
      @(negedge mclk);
      n++;
    end
    if (n >= 400)
      hang();
  endtask
  initial
  begin
    repeat (20) @(posedge mclk);
    rst <= 1'h0;
    rdchk(`PDMC_IDX_SYSCTRL, 32'h0b);
    rdchk(`PDMC_IDX_MODSTBY, 32'h40);
    rdchk(16'h1234, 32'h0);
    for (int b = 0; b < 6; b++)
    begin
      wr(`PDMC_IDX_MODSTBY, 8'h01 << b);
      rdchk(`PDMC_IDX_MODSTBY, 32'h40 | (32'h1 << b));
      tick(1);
      chk(moduleHaltReset, b == 1 ? 6'h00 : 6'h01 << b);
      chk({refreshHalt, refreshCounterClear, cpuHalt}, b == 1 ? 3'h6 : 3'h0);
    end
    wr(`PDMC_IDX_MODSTBY, 8'h00);
    for (int k = 0; k < 2; k++)
    begin
      sleepNow();
      chk({cpuHalt, clockRun, refreshCounterClear}, 3'h6);
      rdchk(`PDMC_IDX_STATUS, 32'h03);
      @(posedge mclk);
      externalIrqLines <= 3'h7;
      periphIrq <= 1'h1;
      irqMasked <= 1'h1;
      tick(4);
      chk(cpuHalt, 1'h1);
      @(posedge mclk);
      externalIrqLines <= 3'h0;
      irqMasked <= k[0];
      nmi <= k[0];
      waitRun();
      @(posedge mclk);
      periphIrq <= 1'h0;
      nmi <= 1'h0;
      irqMasked <= 1'h0;
      tick(1);
      chk(starts, k + 1);
    end
    for (int i = 0; i < 4; i++)
    begin
      wr(`PDMC_IDX_SYSCTRL, {1'h1, codes[i], 4'hb});
      sleepNow();
      chk({clockRun, sysClkPinHigh, refreshCounterClear, moduleHaltReset}, {3'h3, 6'h3d});
      rdchk(`PDMC_IDX_STATUS, 32'h05);
      @(posedge mclk);
      externalIrqLines <= 3'h1 << (i % 3);
      waitRun();
      chk(n >= waits[i] && n <= waits[i] + 5, 1'h1);
      @(posedge mclk);
      externalIrqLines <= 3'h0;
      rdchk(`PDMC_IDX_SYSCTRL, {25'h1, codes[i], 4'hb});
    end
    wr(`PDMC_IDX_SYSCTRL, 8'h0a);
    wr(`PDMC_IDX_MODSTBY, 8'h80);
    tick(1);
    chk({ramEnable, sysClkPinEn}, 2'h0);
    @(posedge mclk);
    hwStandbyPinN <= 1'h0;
    tick(3);
    chk({portsHighZ, cpuRegsUndefined, cpuHalt, moduleHaltReset}, {3'h7, 6'h3f});
    rdchk(`PDMC_IDX_STATUS, 32'h09);
    // writes are refused while the standby pin is low
    wr(`PDMC_IDX_SYSCTRL, 8'h80);
    rdchk(`PDMC_IDX_SYSCTRL, 32'h0b);
    @(posedge mclk);
    hwStandbyPinN <= 1'h1;
    waitRun();
    rdchk(`PDMC_IDX_MODSTBY, 32'h40);
    rdchk(`PDMC_IDX_SYSCTRL, 32'h0b);
    wr(`PDMC_IDX_SYSCTRL, 8'hfb);
    sleepNow();
    @(posedge mclk);
    resetPinN <= 1'h0;
    tick(2);
    chk({cpuHalt, clockRun}, 2'h1);
    @(posedge mclk);
    resetPinN <= 1'h1;
    rdchk(`PDMC_IDX_SYSCTRL, 32'h0b);
    // two sleep wakes and four settle exits; pin exits start no handler
    chk(starts, 32'h6);
    endOfTest();
  end
endmodule
`default_nettype wire
